// ### core/perf_event_map.svh
// Register offsets, field positions, reset values and timing counts of the event monitor.
`ifndef PERF_EVENT_MAP_SVH
`define PERF_EVENT_MAP_SVH

// ==========================================
// Register byte offsets
`define OFS_SEL0 8'h00
`define OFS_SEL1 8'h04
`define OFS_PSTATE 8'h08
`define OFS_THRESH 8'h0C
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14
`define OFS_POWER 8'h18

// ==========================================
// Event codes and fixed umask values
`define EVT_L2_REJECT 8'h30
`define EVT_L2_IDLE 8'h32
`define EVT_PSTATE 8'h3A
`define EVT_TRIP 8'h3B
`define UMASK_PSTATE 8'h00
`define UMASK_TRIP 8'hC0

// ==========================================
// Umask field positions for the reject event
`define UM_CORE_HI 7
`define UM_CORE_LO 6
`define UM_PF_HI 5
`define UM_PF_LO 4
`define UM_MESI_HI 3
`define UM_MESI_LO 0
`define UM_CORE_BOTH 2'h3
`define UM_PF_BOTH 2'h3
`define UM_PF_ONLY 2'h1
`define UM_PF_DEMAND 2'h0

// ==========================================
// Status bit positions
`define ST_REJECT 0
`define ST_TRANS 1
`define ST_TRIP 2
`define ST_WIDTH 3

// ==========================================
// Reset values and low operating point
`define RST_FREQ 4'hF
`define RST_VID 6'h3F
`define RST_THRESH 8'h64
`define LOW_FREQ 4'h2
`define LOW_VID 6'h08

// ==========================================
// Timing: temperature sample period
`define SAMPLE_TIME_US 1000
`define CLK_PERIOD_NS 10
`define SAMPLE_CYCLES ((`SAMPLE_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// ### core/perf_event_pkg.sv
// Types shared by the event monitor.
package perf_event_pkg;

  // Counter event selection.
  typedef struct packed {
    logic [7:0] umask;
    logic [7:0] code;
  } sel_s;

  // Operating point sent to the clock and voltage control.
  typedef struct packed {
    logic [5:0] voltage_identifier;
    logic [3:0] freq;
  } op_s;

  // Attributes of an L2 request seen at the bus queue.
  typedef struct packed {
    logic valid;
    logic prefetch;
    logic [1:0] mesi;
  } l2_req_s;

  // Thermal control state.
  typedef enum logic {
    TH_NORMAL = 1'b0,
    TH_TRIPPED = 1'b1
  } thermal_e;

endpackage

// ### core/perf_event_l2_power_monitor.sv
// Event detection for L2 and power events, thermal control and an AXI4-Lite register file.
// Functional notes
// - Code 30H counts held-back bus-bound L2 requests.
// - Rejection on full queue or same-set entry.
// - Rejection fires every held cycle, count suffices.
// - Reject qualified by core, prefetch, line state.
// - Code 32H counts cycles without outstanding requests.
// - Umask 00H counts every frequency-changing transition.
// - Transitions count only while core is active.
// - Sleep-driven hardware transitions count like software ones; the code counts the entry into sleep only, not the wake-up.
// - Sleep states gate clock and lower operating point.
// - Thermal throttle changes count as transitions.
// - Trip counted when temperature rises above threshold.
// - Trip lowers frequency and voltage automatically.
// - Sample each millisecond, restore when below threshold.
`timescale 1ns/10ps
`include "perf_event_map.svh"

module perf_event_l2_power_monitor
  import perf_event_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire l2_req_s self_req,
  input wire logic bus_queue_full,
  input wire logic bus_queue_set_hit,
  input wire l2_req_s other_reject,
  input wire logic l2_req_outstanding,
  input wire logic [1:0] enhanced_sleep_state,
  input wire logic [7:0] temperature,
  output op_s op_point,
  output logic core_clk_en,
  output logic [1:0] cnt_inc,
  output logic irq
);

  // ==========================================
  // Helpers

  // Merges write data into a register under byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Tests a reject against the umask qualifiers of one counter.
  function automatic logic reject_ok(input logic [7:0] um, input l2_req_s rq, input logic other);
    logic core_ok;
    logic pf_ok;
    core_ok = !other || (um[`UM_CORE_HI:`UM_CORE_LO] == `UM_CORE_BOTH);
    pf_ok = (um[`UM_PF_HI:`UM_PF_LO] == `UM_PF_BOTH) ||
            (um[`UM_PF_HI:`UM_PF_LO] == `UM_PF_ONLY && rq.prefetch) ||
            (um[`UM_PF_HI:`UM_PF_LO] == `UM_PF_DEMAND && !rq.prefetch);
    return rq.valid && core_ok && pf_ok && um[`UM_MESI_LO + rq.mesi];
  endfunction

  // ==========================================
  // AXI4-Lite slave

  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_val;
  logic [31:0] sel_wr [2];
  sel_s sel_q [2];
  op_s sw_op_q;
  logic [7:0] thresh_q;
  logic [`ST_WIDTH-1:0] status_q;
  logic [`ST_WIDTH-1:0] mask_q;
  op_s op_q;
  op_s op_d;
  thermal_e therm_q;
  logic [1:0] cstate_q;

  // Address and data are taken in either order, then written together.
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_hit = awaddr_q[1:0] == 2'h0 && awaddr_q <= `OFS_POWER && awaddr_q != `OFS_POWER;

  // Captures the write channels and raises the response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero with an error response.
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_SEL0: rd_val = {16'h0000, sel_q[0]};
      `OFS_SEL1: rd_val = {16'h0000, sel_q[1]};
      `OFS_PSTATE: rd_val = {18'h0_0000, sw_op_q.voltage_identifier, 4'h0, sw_op_q.freq};
      `OFS_THRESH: rd_val = {24'h00_0000, thresh_q};
      `OFS_STATUS: rd_val = {29'h0000_0000, status_q};
      `OFS_MASK: rd_val = {29'h0000_0000, mask_q};
      `OFS_POWER: rd_val = {temperature, 5'h00, therm_q, cstate_q, 2'h0, op_q.voltage_identifier, 4'h0, op_q.freq};
      default: rd_hit = 1'b0;
    endcase
  end

  // Returns read data one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Byte-merged write values of the two selection registers.
  assign sel_wr[0] = merge({16'h0000, sel_q[0]}, wdata_q, wstrb_q);
  assign sel_wr[1] = merge({16'h0000, sel_q[1]}, wdata_q, wstrb_q);

  // Software-written control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q[0] <= '0;
      sel_q[1] <= '0;
      sw_op_q <= '{voltage_identifier: `RST_VID, freq: `RST_FREQ};
      thresh_q <= `RST_THRESH;
      mask_q <= '0;
    end else if (wr_fire) begin
      case (awaddr_q)
        `OFS_SEL0: sel_q[0] <= sel_wr[0][15:0];
        `OFS_SEL1: sel_q[1] <= sel_wr[1][15:0];
        `OFS_PSTATE: begin
          sw_op_q.freq <= wstrb_q[0] ? wdata_q[3:0] : sw_op_q.freq;
          sw_op_q.voltage_identifier <= wstrb_q[1] ? wdata_q[13:8] : sw_op_q.voltage_identifier;
        end
        `OFS_THRESH: thresh_q <= wstrb_q[0] ? wdata_q[7:0] : thresh_q;
        `OFS_MASK: mask_q <= wstrb_q[0] ? wdata_q[`ST_WIDTH-1:0] : mask_q;
        default: ;
      endcase
    end
  end

  // ==========================================
  // L2 events

  logic self_reject;
  l2_req_s self_rej;

  // queue full or set conflict
  // A bus-bound request is held back while the queue cannot take it.
  assign self_reject = self_req.valid && (bus_queue_full || bus_queue_set_hit);
  assign self_rej = '{valid: self_reject, prefetch: self_req.prefetch, mesi: self_req.mesi};

  // ==========================================
  // Thermal control

  logic [16:0] tick_cnt_q;
  logic tick;
  logic trip_evt;

  // Free-running divider giving a one-cycle sample enable each millisecond.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 17'h0_0000;
    end else if (tick) begin
      tick_cnt_q <= 17'h0_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 17'h0_0001;
    end
  end
  assign tick = tick_cnt_q == 17'(SAMPLE_CYCLES - 1);

  assign trip_evt = tick && therm_q == TH_NORMAL && temperature > thresh_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      therm_q <= TH_NORMAL;
    end else if (trip_evt) begin
      therm_q <= TH_TRIPPED;
    end else if (tick && therm_q == TH_TRIPPED && temperature < thresh_q) begin
      therm_q <= TH_NORMAL;
    end
  end

  // ==========================================
  // Operating point and transitions

  logic trans_evt;

  always_comb begin
    op_d = sw_op_q;
    if (therm_q == TH_TRIPPED || enhanced_sleep_state != 2'h0) begin
      op_d = '{voltage_identifier: `LOW_VID, freq: `LOW_FREQ};
    end
  end

  // Applies the operating point and tracks the sleep state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_q <= '{voltage_identifier: `RST_VID, freq: `RST_FREQ};
      cstate_q <= 2'h0;
      core_clk_en <= 1'b1;
    end else begin
      op_q <= op_d;
      cstate_q <= enhanced_sleep_state;
      core_clk_en <= enhanced_sleep_state == 2'h0;
    end
  end
  assign op_point = op_q;

  assign trans_evt = op_d.freq != op_q.freq && cstate_q == 2'h0;

  // ==========================================
  // Counter increments

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_inc <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        case (sel_q[i].code)
          `EVT_L2_REJECT: cnt_inc[i] <= reject_ok(sel_q[i].umask, self_rej, 1'b0) ||
                                        reject_ok(sel_q[i].umask, other_reject, 1'b1);
          `EVT_L2_IDLE: cnt_inc[i] <= !l2_req_outstanding;
          `EVT_PSTATE: cnt_inc[i] <= trans_evt && sel_q[i].umask == `UMASK_PSTATE;
          `EVT_TRIP: cnt_inc[i] <= trip_evt && sel_q[i].umask == `UMASK_TRIP;
          default: cnt_inc[i] <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================
  // Interrupt status

  logic [`ST_WIDTH-1:0] st_set;
  logic [`ST_WIDTH-1:0] st_clr;
  assign st_set = {trip_evt, trans_evt, self_reject};
  assign st_clr = (wr_fire && awaddr_q == `OFS_STATUS && wstrb_q[0]) ? wdata_q[`ST_WIDTH-1:0] : '0;

  // Sticky bits, write one to clear; a new event wins over the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end
  assign irq = |(status_q & mask_q);

  // ==========================================
  // Assertions

  sequence trip_seq;
    tick && therm_q == TH_NORMAL && temperature > thresh_q;
  endsequence

  sequence low_point_seq;
    op_q.freq == `LOW_FREQ && op_q.voltage_identifier == `LOW_VID;
  endsequence

  reject_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
    self_req.valid && bus_queue_full && sel_q[0] == sel_s'{umask: 8'hFF, code: `EVT_L2_REJECT} |=> cnt_inc[0])
    else $error("held request not counted");
  reject_core_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_q[1].code == `EVT_L2_REJECT && sel_q[1].umask[7:6] != 2'h3 && !self_reject |=> !cnt_inc[1])
    else $error("other core reject counted for this core only");
  idle_cycle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_q[1].code == `EVT_L2_IDLE |=> cnt_inc[1] == !$past(l2_req_outstanding))
    else $error("idle cycle count wrong");
  trans_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_d.freq != op_q.freq && cstate_q == 2'h0 && sel_q[1] == sel_s'{umask: `UMASK_PSTATE, code: `EVT_PSTATE}
    |=> cnt_inc[1])
    else $error("transition not counted");
  trans_sleep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cstate_q != 2'h0 && sel_q[1] == sel_s'{umask: `UMASK_PSTATE, code: `EVT_PSTATE} |=> !cnt_inc[1])
    else $error("transition counted while asleep");
  sleep_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enhanced_sleep_state != 2'h0 && $stable(enhanced_sleep_state) |=> !core_clk_en and low_point_seq)
    else $error("sleep did not gate clock or lower point");
  trip_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    trip_seq |=> therm_q == TH_TRIPPED ##1 low_point_seq)
    else $error("trip did not lower operating point");
  trip_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    therm_q == TH_TRIPPED && !tick |=> therm_q == TH_TRIPPED)
    else $error("thermal state left between samples");
  pulse_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_inc[0] |-> $past(sel_q[0].code) inside {`EVT_L2_REJECT, `EVT_L2_IDLE, `EVT_PSTATE, `EVT_TRIP} &&
    ($past(sel_q[0].code) != `EVT_TRIP || $past(sel_q[0].umask) == `UMASK_TRIP))
    else $error("pulse without matching selection");

endmodule

// ### test/l2_power_source.sv
// Behavioural model of the L2 controller, bus queue and power sensors.
`timescale 1ns/10ps
module l2_power_source
  import perf_event_pkg::*;
(
  input wire logic aclk,
  output l2_req_s self_req,
  output logic bus_queue_full,
  output logic bus_queue_set_hit,
  output l2_req_s other_reject,
  output logic l2_req_outstanding,
  output logic [1:0] enhanced_sleep_state,
  output logic [7:0] temperature
);
  // Quiet start: nothing pending in the queue, a request outstanding, core active and cool.
  initial begin
    self_req = '0;
    other_reject = '0;
    bus_queue_full = 1'b0;
    bus_queue_set_hit = 1'b0;
    l2_req_outstanding = 1'b1;
    enhanced_sleep_state = 2'h0;
    temperature = 8'h20;
  end

  // Presents one request for n cycles under the given queue state; released fields are scrambled so stale values never match.
  task automatic reject(input int n, input logic full, input logic hit, input logic pf, input logic oth);
    @(posedge aclk);
    if (oth) begin
      other_reject <= '{1'b1, pf, 2'h0};
    end else begin
      self_req <= '{1'b1, pf, 2'h0};
    end
    bus_queue_full <= full;
    bus_queue_set_hit <= hit;
    repeat (n) @(posedge aclk);
    self_req <= '{1'b0, ~pf, 2'h3};
    other_reject <= '{1'b0, ~pf, 2'h3};
    bus_queue_full <= 1'b0;
    bus_queue_set_hit <= 1'b0;
  endtask

  // Leaves the L2 with nothing outstanding for n cycles.
  task automatic idle(input int n);
    @(posedge aclk);
    l2_req_outstanding <= 1'b0;
    repeat (n) @(posedge aclk);
    l2_req_outstanding <= 1'b1;
  endtask

  // Sets the sleep level and the die temperature.
  task automatic sense(input logic [1:0] s, input logic [7:0] t);
    @(posedge aclk);
    enhanced_sleep_state <= s;
    temperature <= t;
  endtask
endmodule

// ### test/tb_perf_event_l2_power_monitor.sv
// Self-checking testbench of the L2 and power event monitor.
`timescale 1ns/10ps
`include "perf_event_map.svh"
module tb_perf_event_l2_power_monitor
  import perf_event_pkg::*;
();
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, core_clk_en, irq;
  logic bus_queue_full, bus_queue_set_hit, l2_req_outstanding;
  logic [7:0] s_axi_awaddr, s_axi_araddr, temperature;
  logic [31:0] s_axi_wdata, s_axi_rdata, b0, b1;
  logic [31:0] c0 = '0;
  logic [31:0] c1 = '0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, enhanced_sleep_state, cnt_inc;
  l2_req_s self_req, other_reject;
  op_s op_point;
  int fails, n_checks, s;

  // ==========================================
  // Design, far-side model and pulse counters
  perf_event_l2_power_monitor #(.SAMPLE_CYCLES(20)) i_perf_event_l2_power_monitor (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .self_req(self_req), .bus_queue_full(bus_queue_full), .bus_queue_set_hit(bus_queue_set_hit),
    .other_reject(other_reject), .l2_req_outstanding(l2_req_outstanding),
    .enhanced_sleep_state(enhanced_sleep_state), .temperature(temperature), .op_point(op_point),
    .core_clk_en(core_clk_en), .cnt_inc(cnt_inc), .irq(irq));
  l2_power_source i_l2_power_source (.aclk(aclk), .self_req(self_req), .bus_queue_full(bus_queue_full),
    .bus_queue_set_hit(bus_queue_set_hit), .other_reject(other_reject), .l2_req_outstanding(l2_req_outstanding),
    .enhanced_sleep_state(enhanced_sleep_state), .temperature(temperature));

  // Totals the increment pulses of both counters; reset keeps the unknown start value out.
  always @(posedge aclk) begin
    if (!aresetn) begin
      c0 <= '0;
      c1 <= '0;
    end else begin
      c0 <= c0 + {31'h0, cnt_inc[0]};
      c1 <= c1 + {31'h0, cnt_inc[1]};
    end
  end

  // ==========================================
  // Tasks
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Writes one word; a channel is released after the edge at which it was taken.
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, sa, sw;
    logic [1:0] rsp;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      sa = s_axi_awvalid && s_axi_awready;
      sw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (sa) s_axi_awvalid <= 1'b0;
      if (sw) s_axi_wvalid <= 1'b0;
      ta = ta | sa;
      tw = tw | sw;
    end
    sa = 1'b0;
    while (!sa) begin
      @(negedge aclk);
      sa = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
    end
    chk({30'h0, rsp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Reads one word and compares it.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic sa;
    logic [31:0] rd;
    sa = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!sa) begin
      @(negedge aclk);
      sa = s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    sa = 1'b0;
    while (!sa) begin
      @(negedge aclk);
      sa = s_axi_rvalid;
      rd = s_axi_rdata;
      @(posedge aclk);
    end
    chk(rd, exp);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Notes the counts before a scenario, then checks how many pulses each counter got.
  task automatic mark();
    b0 = c0;
    b1 = c1;
  endtask
  task automatic cnt(input logic [31:0] e0, input logic [31:0] e1);
    repeat (3) @(posedge aclk);
    chk(c0 - b0, e0);
    chk(c1 - b1, e1);
  endtask

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================
  // Clock, watchdog and test sequence
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_of_test();
  end

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({22'h0, op_point}, {22'h0, 6'h3F, 4'hF});
    chk({31'h0, core_clk_en}, 32'h0000_0001);
    rchk(`OFS_THRESH, 32'h0000_0064);
    wchk(`OFS_POWER, 32'h0000_0000, 2'h2);
    wchk(8'h1C, 32'h0000_0000, 2'h2);
    wchk(`OFS_SEL0, 32'h0000_FF30, 2'h0);
    wchk(`OFS_SEL1, 32'h0000_3F30, 2'h0);
    mark();
    i_l2_power_source.reject(3, 1'b1, 1'b0, 1'b0, 1'b0);
    cnt(32'h0000_0003, 32'h0000_0003);
    mark();
    i_l2_power_source.reject(2, 1'b0, 1'b1, 1'b1, 1'b0);
    cnt(32'h0000_0002, 32'h0000_0002);
    mark();
    i_l2_power_source.reject(3, 1'b0, 1'b0, 1'b0, 1'b0);
    cnt(32'h0000_0000, 32'h0000_0000);
    mark();
    i_l2_power_source.reject(2, 1'b0, 1'b0, 1'b0, 1'b1);
    cnt(32'h0000_0002, 32'h0000_0000);
    wchk(`OFS_SEL1, 32'h0000_CF30, 2'h0);
    mark();
    i_l2_power_source.reject(2, 1'b1, 1'b0, 1'b1, 1'b0);
    cnt(32'h0000_0002, 32'h0000_0000);
    wchk(`OFS_SEL1, 32'h0000_FE30, 2'h0);
    mark();
    i_l2_power_source.reject(2, 1'b1, 1'b0, 1'b0, 1'b0);
    cnt(32'h0000_0002, 32'h0000_0000);
    wchk(`OFS_SEL1, 32'h0000_0032, 2'h0);
    mark();
    i_l2_power_source.idle(5);
    cnt(32'h0000_0000, 32'h0000_0005);
    wchk(`OFS_SEL0, 32'h0000_C03B, 2'h0);
    wchk(`OFS_SEL1, 32'h0000_003A, 2'h0);
    for (s = 1; s < 4; s++) begin
      mark();
      i_l2_power_source.sense(s[1:0], 8'h20);
      repeat (3) @(posedge aclk);
      chk({31'h0, core_clk_en}, 32'h0000_0000);
      chk({22'h0, op_point}, {22'h0, 6'h08, 4'h2});
      i_l2_power_source.sense(2'h0, 8'h20);
      cnt(32'h0000_0000, 32'h0000_0001);
    end
    wchk(`OFS_STATUS, 32'h0000_0007, 2'h0);
    mark();
    i_l2_power_source.sense(2'h0, 8'h70);
    repeat (45) @(posedge aclk);
    chk({22'h0, op_point}, {22'h0, 6'h08, 4'h2});
    cnt(32'h0000_0001, 32'h0000_0001);
    rchk(`OFS_STATUS, 32'h0000_0006);
    wchk(`OFS_MASK, 32'h0000_0004, 2'h0);
    chk({31'h0, irq}, 32'h0000_0001);
    wchk(`OFS_STATUS, 32'h0000_0004, 2'h0);
    chk({31'h0, irq}, 32'h0000_0000);
    mark();
    i_l2_power_source.sense(2'h0, 8'h50);
    repeat (45) @(posedge aclk);
    chk({22'h0, op_point}, {22'h0, 6'h3F, 4'hF});
    cnt(32'h0000_0000, 32'h0000_0001);
    mark();
    wchk(`OFS_PSTATE, 32'h0000_2005, 2'h0);
    chk({22'h0, op_point}, {22'h0, 6'h20, 4'h5});
    cnt(32'h0000_0000, 32'h0000_0001);
    mark();
    wchk(`OFS_PSTATE, 32'h0000_3005, 2'h0);
    cnt(32'h0000_0000, 32'h0000_0000);
    end_of_test();
  end
endmodule
